/* File: hw/dpom_pkg.sv */
// Purpose: shared constants for the dpll phase offset and measurement block
// Assumes: 32-bit apb, one register per aligned word, core clock 100 MHz
// Notes:   offsets are byte addresses; readout bytes sit in the low bits
`default_nettype none
package dpom_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_MASTER_CONFIG_TEN      = 8'h00;
   localparam logic [7:0] ADDR_FRAME_SYNC_CONFIG_THREE = 8'h04;
   localparam logic [7:0] ADDR_MAIN_LOOP_CONFIG_ONE   = 8'h08;
   localparam logic [7:0] ADDR_MASTER_CONFIG_FOUR     = 8'h0C;
   localparam logic [7:0] ADDR_MASTER_CONFIG_ELEVEN   = 8'h10;
   localparam logic [7:0] ADDR_PHASE_OFFSET           = 8'h14;
   localparam logic [7:0] ADDR_BUILDOUT_SKEW          = 8'h18;
   localparam logic [7:0] ADDR_MASTER_CLOCK_TRIM      = 8'h1C;
   localparam logic [7:0] ADDR_STATUS                 = 8'h20;
   localparam logic [7:0] ADDR_FREQ1                  = 8'h24;
   localparam logic [7:0] ADDR_FREQ2                  = 8'h28;
   localparam logic [7:0] ADDR_FREQ3                  = 8'h2C;
   localparam logic [7:0] ADDR_PHASE1                 = 8'h30;
   localparam logic [7:0] ADDR_PHASE2                 = 8'h34;

   // field positions
   localparam int BIT_BUILDOUT_ENABLE  = 0;
   localparam int BIT_RECALIBRATE_TRIGGER_TRIGGER    = 0;
   localparam int BIT_CROSS_MEASURE    = 0;
   localparam int BIT_MEAS_SOURCE      = 0;
   localparam int BIT_STATUS_RECALIBRATE_TRIGGER     = 0;
   localparam int BIT_STATUS_HOLDOVER  = 1;
   localparam int AUX_SEL_W            = 4;

   // reset values
   localparam logic [16:0] RST_PHASE_OFFSET  = 17'h00000;
   localparam logic [7:0]  RST_BUILDOUT_SKEW = 8'h00;
   localparam logic [15:0] RST_CLOCK_TRIM    = 16'h0000;
   localparam logic [3:0]  RST_AUX_SEL       = 4'h0;

   // manual phase offset: span and step in picoseconds
   localparam int OFFSET_SPAN_PS = 200000;
   localparam int OFFSET_STEP_PS = 6;
   localparam logic signed [17:0] OFFSET_MAX = 18'(OFFSET_SPAN_PS / OFFSET_STEP_PS);
   localparam logic signed [17:0] RAMP_STEP  = 18'h00010;

   // frequency readout: +-80 ppm at 0.0003068 ppm per count (units of 1e-7 ppm)
   localparam int FREQ_RANGE_E7 = 800000000;
   localparam int FREQ_STEP_E7  = 3068;
   localparam logic signed [23:0] FREQ_MAX = 24'(FREQ_RANGE_E7 / FREQ_STEP_E7);

   // phase averaging: one-pole filter, coefficient 2^-shift per pd sample
   localparam int PHASE_AVG_SHIFT = 4;

   // dpll operating states reported by the loop core
   localparam logic [1:0] ST_FREERUN  = 2'h0;
   localparam logic [1:0] ST_HOLDOVER = 2'h1;
   localparam logic [1:0] ST_LOCKING  = 2'h2;
   localparam logic [1:0] ST_LOCKED   = 2'h3;

   // input locking modes
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_EIGHT_KHZ_LOCK_MODE = 2'h1;
   localparam logic [1:0] MODE_DIVIDE_BY_N_MODE   = 2'h2;
endpackage : dpom_pkg
`default_nettype wire

/* File: hw/dpom_top.sv */
// Purpose: phase build-out skew, manual phase offset, recalibration and
//          frequency/phase readout for the main and auxiliary dplls
// Assumes: loop core runs on core_clk, so its signals need no synchroniser
// Notes:   registers over apb; readouts snapshot on their first byte read
//
// Local design decisions: the APB interface to the registers and the register addresses.
`default_nettype none

module dpom_top (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               ce,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // loop core status and measurements
   input  wire logic [1:0]         main_dpll_state,
   input  wire logic               buildout_event,
   input  wire logic signed [17:0] buildout_phase,
   input  wire logic signed [23:0] main_integral,
   input  wire logic signed [23:0] aux_integral,
   input  wire logic               pd_sample,
   input  wire logic signed [15:0] main_pd_diff,
   input  wire logic signed [15:0] aux_pd_diff,
   input  wire logic [1:0]         main_ref_mode,
   input  wire logic               main_divide_by_n_mode_is_8k,
   input  wire logic [1:0]         aux_ref_mode,
   input  wire logic               aux_divide_by_n_mode_is_8k,
   // controls to the loop core
   output logic signed [16:0]      feedback_phase_offset,
   output logic                    mini_holdover,
   output logic                    divider_reset,
   output logic [3:0]              aux_forced_input,
   output logic                    aux_lock_disable,
   output logic                    aux_pd_main_copy,
   output logic [1:0]              main_copy_mode,
   output logic signed [15:0]      reference_trim
);

   typedef enum logic [2:0] {
      RC_IDLE, RC_HOLD, RC_DOWN, RC_DIVRST, RC_UP, RC_EXIT
   } dpom_recalibrate_trigger_t;

   logic                    buildout_enable_reg;
   logic                    recalibrate_trigger_req_reg;
   logic                    cross_measure_enable_reg;
   logic                    measurement_source_select_reg;
   logic [3:0]              aux_forced_input_select_reg;
   logic signed [16:0]      phase_offset_reg;
   logic signed [7:0]       buildout_event_skew_reg;
   logic signed [15:0]      master_clock_trim_reg;
   logic signed [16:0]      buildout_accum_reg;
   logic signed [16:0]      applied_reg;
   logic signed [16:0]      target_next;
   dpom_recalibrate_trigger_t             recalibrate_trigger_reg;
   logic [31:0]             prdata_reg;
   logic                    pslverr_reg;
   logic signed [23:0]      freq_snap_reg;
   logic signed [15:0]      phase_snap_reg;
   logic signed [23:0]      freq_live;
   logic signed [15:0]      phase_live;
   logic signed [15:0]      phase_avg [2];
   logic                    wr_en;
   logic                    rd_setup;
   logic signed [17:0]      wr_offset;
   logic signed [17:0]      bo_sum;
   logic signed [17:0]      ramp_diff;
   logic signed [24:0]      freq_corr;
   logic                    ramp_allowed;

   // apb: data captured at setup, so every access completes in one wait-free cycle
   assign pready   = 1'b1;
   assign prdata   = prdata_reg;
   assign pslverr  = pslverr_reg;
   assign wr_en    = ce & psel & penable & pwrite;
   assign rd_setup = ce & psel & ~penable & ~pwrite;

   // written offsets saturate at the documented span
   assign wr_offset = (18'(signed'(pwdata[16:0])) > dpom_pkg::OFFSET_MAX) ?
                      dpom_pkg::OFFSET_MAX :
                      (18'(signed'(pwdata[16:0])) < -dpom_pkg::OFFSET_MAX) ?
                      -dpom_pkg::OFFSET_MAX : 18'(signed'(pwdata[16:0]));

   // software control registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         buildout_enable_reg           <= 1'b0;
         cross_measure_enable_reg      <= 1'b0;
         measurement_source_select_reg <= 1'b0;
         aux_forced_input_select_reg   <= dpom_pkg::RST_AUX_SEL;
         phase_offset_reg              <= dpom_pkg::RST_PHASE_OFFSET;
         buildout_event_skew_reg       <= dpom_pkg::RST_BUILDOUT_SKEW;
         master_clock_trim_reg         <= dpom_pkg::RST_CLOCK_TRIM;
      end else if (wr_en) begin
         case (paddr)
            dpom_pkg::ADDR_MASTER_CONFIG_TEN:
               buildout_enable_reg <= pwdata[dpom_pkg::BIT_BUILDOUT_ENABLE];
            dpom_pkg::ADDR_MAIN_LOOP_CONFIG_ONE:
               cross_measure_enable_reg <= pwdata[dpom_pkg::BIT_CROSS_MEASURE];
            dpom_pkg::ADDR_MASTER_CONFIG_ELEVEN:
               measurement_source_select_reg <= pwdata[dpom_pkg::BIT_MEAS_SOURCE];
            dpom_pkg::ADDR_MASTER_CONFIG_FOUR:
               aux_forced_input_select_reg <= pwdata[dpom_pkg::AUX_SEL_W-1:0];
            dpom_pkg::ADDR_PHASE_OFFSET:
               phase_offset_reg <= wr_offset[16:0];
            dpom_pkg::ADDR_BUILDOUT_SKEW:
               buildout_event_skew_reg <= pwdata[7:0];
            dpom_pkg::ADDR_MASTER_CLOCK_TRIM:
               master_clock_trim_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // recalibrate request: a new set wins over the sequencer taking it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         recalibrate_trigger_req_reg <= 1'b0;
      end else if (ce) begin
         if (wr_en && paddr == dpom_pkg::ADDR_FRAME_SYNC_CONFIG_THREE &&
             pwdata[dpom_pkg::BIT_RECALIBRATE_TRIGGER_TRIGGER]) begin
            recalibrate_trigger_req_reg <= 1'b1;
         end else if (recalibrate_trigger_reg == RC_IDLE) begin
            recalibrate_trigger_req_reg <= 1'b0;
         end
      end
   end

   // build-out phase plus the fixed per-event skew, saturated to the offset span
   assign bo_sum = buildout_phase + 18'(buildout_event_skew_reg);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         buildout_accum_reg <= '0;
      end else if (ce) begin
         if (!buildout_enable_reg) begin
            buildout_accum_reg <= '0;
         end else if (buildout_event) begin
            if (bo_sum > dpom_pkg::OFFSET_MAX) begin
               buildout_accum_reg <= dpom_pkg::OFFSET_MAX[16:0];
            end else if (bo_sum < -dpom_pkg::OFFSET_MAX) begin
               buildout_accum_reg <= 17'(-dpom_pkg::OFFSET_MAX);
            end else begin
               buildout_accum_reg <= bo_sum[16:0];
            end
         end
      end
   end

   // target of the feedback offset ramp
   always_comb begin
      target_next = phase_offset_reg;
      case (recalibrate_trigger_reg)
         RC_HOLD, RC_DOWN, RC_DIVRST: target_next = '0;
         RC_UP, RC_EXIT:              target_next = phase_offset_reg;
         default: begin
            if (buildout_enable_reg) begin
               target_next = buildout_accum_reg;
            end else begin
               target_next = phase_offset_reg;
            end
         end
      endcase
   end

   // outside free-run and holdover only; the sequencer may ramp in its own holdover
   assign ramp_allowed = (main_dpll_state == dpom_pkg::ST_LOCKING) ||
                         (main_dpll_state == dpom_pkg::ST_LOCKED) ||
                         (recalibrate_trigger_reg != RC_IDLE);
   assign ramp_diff    = 18'(target_next) - 18'(applied_reg);

   // stepped ramp keeps the loop from seeing a phase jump
   always_ff @(posedge core_clk) begin
      if (rst) begin
         applied_reg <= '0;
      end else if (ce && ramp_allowed) begin
         if (ramp_diff > dpom_pkg::RAMP_STEP) begin
            applied_reg <= 17'(18'(applied_reg) + dpom_pkg::RAMP_STEP);
         end else if (ramp_diff < -dpom_pkg::RAMP_STEP) begin
            applied_reg <= 17'(18'(applied_reg) - dpom_pkg::RAMP_STEP);
         end else begin
            applied_reg <= target_next;
         end
      end
   end

   // offset goes to the feedback synthesizer; the loop filter sets output slew
   assign feedback_phase_offset = applied_reg;

   // recalibration sequencer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         recalibrate_trigger_reg <= RC_IDLE;
      end else if (ce) begin
         case (recalibrate_trigger_reg)
            RC_IDLE:   if (recalibrate_trigger_req_reg) recalibrate_trigger_reg <= RC_HOLD;
            RC_HOLD:   recalibrate_trigger_reg <= RC_DOWN;
            RC_DOWN:   if (applied_reg == '0) recalibrate_trigger_reg <= RC_DIVRST;
            RC_DIVRST: recalibrate_trigger_reg <= RC_UP;
            RC_UP:     if (applied_reg == phase_offset_reg) recalibrate_trigger_reg <= RC_EXIT;
            RC_EXIT:   recalibrate_trigger_reg <= RC_IDLE;
            default:   recalibrate_trigger_reg <= RC_IDLE;
         endcase
      end
   end

   // sequencer outputs, registered so the core sees clean levels
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mini_holdover <= 1'b0;
         divider_reset <= 1'b0;
      end else if (ce) begin
         mini_holdover <= (recalibrate_trigger_reg == RC_HOLD) || (recalibrate_trigger_reg == RC_DOWN) ||
                          (recalibrate_trigger_reg == RC_DIVRST) || (recalibrate_trigger_reg == RC_UP);
         divider_reset <= (recalibrate_trigger_reg == RC_DIVRST);
      end
   end

   // cross-measure routing for the auxiliary phase detector
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aux_forced_input <= dpom_pkg::RST_AUX_SEL;
         aux_lock_disable <= 1'b0;
         aux_pd_main_copy <= 1'b0;
         main_copy_mode   <= dpom_pkg::MODE_DIRECT;
         reference_trim   <= dpom_pkg::RST_CLOCK_TRIM;
      end else if (ce) begin
         aux_forced_input <= aux_forced_input_select_reg;
         aux_lock_disable <= cross_measure_enable_reg;
         aux_pd_main_copy <= cross_measure_enable_reg;
         reference_trim   <= master_clock_trim_reg;
         // copy is divided only when the auxiliary path itself runs at 8 kHz
         if (aux_ref_mode == dpom_pkg::MODE_EIGHT_KHZ_LOCK_MODE ||
             (aux_ref_mode == dpom_pkg::MODE_DIVIDE_BY_N_MODE && aux_divide_by_n_mode_is_8k)) begin
            if (main_ref_mode == dpom_pkg::MODE_DIRECT ||
                main_ref_mode == dpom_pkg::MODE_EIGHT_KHZ_LOCK_MODE) begin
               main_copy_mode <= dpom_pkg::MODE_EIGHT_KHZ_LOCK_MODE;
            end else if (main_ref_mode == dpom_pkg::MODE_DIVIDE_BY_N_MODE && main_divide_by_n_mode_is_8k) begin
               main_copy_mode <= dpom_pkg::MODE_DIVIDE_BY_N_MODE;
            end else begin
               main_copy_mode <= dpom_pkg::MODE_DIRECT;
            end
         end else begin
            // undivided: software keeps both references the same rate
            main_copy_mode <= dpom_pkg::MODE_DIRECT;
         end
      end
   end

   // phase detector averaging, one filter per dpll so switching source needs no settle
   for (genvar g = 0; g < 2; g++) begin : g_phase_avg
      logic signed [15:0] pd_in;
      logic signed [19:0] acc_reg;
      logic signed [20:0] err;
      assign pd_in = (g == 0) ? main_pd_diff : aux_pd_diff;
      // concatenation is unsigned, so the sign is restored before widening
      assign err   = 21'(signed'({pd_in, 4'h0})) - 21'(acc_reg);
      always_ff @(posedge core_clk) begin
         if (rst) begin
            acc_reg <= '0;
         end else if (ce && pd_sample) begin
            acc_reg <= 20'(21'(acc_reg) + (err >>> dpom_pkg::PHASE_AVG_SHIFT));
         end
      end
      assign phase_avg[g] = acc_reg[19:4];
   end

   assign phase_live = measurement_source_select_reg ? phase_avg[1] : phase_avg[0];

   // integral path value corrected by the master clock trim, clamped to range
   assign freq_corr = (measurement_source_select_reg ? 25'(aux_integral) :
                       25'(main_integral)) - 25'(master_clock_trim_reg);
   assign freq_live = (freq_corr > 25'(dpom_pkg::FREQ_MAX)) ? dpom_pkg::FREQ_MAX :
                      (freq_corr < -25'(dpom_pkg::FREQ_MAX)) ? -dpom_pkg::FREQ_MAX :
                      freq_corr[23:0];

   // readout snapshots taken on the first byte so later bytes match it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         freq_snap_reg  <= '0;
         phase_snap_reg <= '0;
      end else if (rd_setup) begin
         if (paddr == dpom_pkg::ADDR_FREQ1) begin
            freq_snap_reg <= freq_live;
         end
         if (paddr == dpom_pkg::ADDR_PHASE1) begin
            phase_snap_reg <= phase_live;
         end
      end
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (ce && psel && !penable) begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
         case (paddr)
            dpom_pkg::ADDR_MASTER_CONFIG_TEN:
               prdata_reg[dpom_pkg::BIT_BUILDOUT_ENABLE] <= buildout_enable_reg;
            dpom_pkg::ADDR_FRAME_SYNC_CONFIG_THREE:
               prdata_reg[dpom_pkg::BIT_RECALIBRATE_TRIGGER_TRIGGER] <= recalibrate_trigger_req_reg;
            dpom_pkg::ADDR_MAIN_LOOP_CONFIG_ONE:
               prdata_reg[dpom_pkg::BIT_CROSS_MEASURE] <= cross_measure_enable_reg;
            dpom_pkg::ADDR_MASTER_CONFIG_FOUR:
               prdata_reg[dpom_pkg::AUX_SEL_W-1:0] <= aux_forced_input_select_reg;
            dpom_pkg::ADDR_MASTER_CONFIG_ELEVEN:
               prdata_reg[dpom_pkg::BIT_MEAS_SOURCE] <= measurement_source_select_reg;
            dpom_pkg::ADDR_PHASE_OFFSET:
               prdata_reg <= 32'(phase_offset_reg);
            dpom_pkg::ADDR_BUILDOUT_SKEW:
               prdata_reg[7:0] <= buildout_event_skew_reg;
            dpom_pkg::ADDR_MASTER_CLOCK_TRIM:
               prdata_reg[15:0] <= master_clock_trim_reg;
            dpom_pkg::ADDR_STATUS: begin
               prdata_reg[dpom_pkg::BIT_STATUS_RECALIBRATE_TRIGGER]    <= (recalibrate_trigger_reg != RC_IDLE);
               prdata_reg[dpom_pkg::BIT_STATUS_HOLDOVER] <= mini_holdover;
            end
            dpom_pkg::ADDR_FREQ1:  prdata_reg[7:0] <= freq_live[7:0];
            dpom_pkg::ADDR_FREQ2:  prdata_reg[7:0] <= freq_snap_reg[15:8];
            dpom_pkg::ADDR_FREQ3:  prdata_reg[7:0] <= freq_snap_reg[23:16];
            dpom_pkg::ADDR_PHASE1: prdata_reg[7:0] <= phase_live[7:0];
            dpom_pkg::ADDR_PHASE2: prdata_reg[7:0] <= phase_snap_reg[15:8];
            default:               pslverr_reg <= 1'b1;
         endcase
      end
   end

endmodule : dpom_top
`default_nettype wire

/* File: verification/dpom_monitor.sv */
// Purpose: port-level checks for dpom_top
// Assumes: one clock domain, rst synchronous and active high
// Notes:   bound to every dpom_top at the foot of this file
`default_nettype none
module dpom_monitor (
   input wire logic               core_clk,
   input wire logic               rst,
   input wire logic               ce,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [1:0]         main_dpll_state,
   input wire logic [1:0]         aux_ref_mode,
   input wire logic signed [16:0] feedback_phase_offset,
   input wire logic               mini_holdover,
   input wire logic               divider_reset,
   input wire logic [3:0]         aux_forced_input,
   input wire logic               aux_lock_disable,
   input wire logic               aux_pd_main_copy,
   input wire logic [1:0]         main_copy_mode
);
   logic        wr;
   // write strobe at the access edge; routing outputs follow the register one edge later
   assign wr = psel && penable && pwrite && ce;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_cross_bit: assert property (wr && paddr == dpom_pkg::ADDR_MAIN_LOOP_CONFIG_ONE
      |-> ##2 aux_lock_disable == $past(pwdata[0], 2)) else $error("cross bit lost");
   a_cross_pair: assert property (wr && paddr == dpom_pkg::ADDR_MAIN_LOOP_CONFIG_ONE
      |-> ##2 aux_pd_main_copy == $past(pwdata[0], 2)) else $error("copy compare lost");
   a_aux_select: assert property (wr && paddr == dpom_pkg::ADDR_MASTER_CONFIG_FOUR
      |-> ##2 aux_forced_input == $past(pwdata[3:0], 2)) else $error("forced input lost");
   a_copy_direct: assert property (aux_pd_main_copy && aux_ref_mode == 2'h0
      |=> main_copy_mode == dpom_pkg::MODE_DIRECT) else $error("copy divided on direct path");
   a_div_once: assert property (divider_reset |=> !divider_reset)
      else $error("divider reset longer than one cycle");
   a_div_at_zero: assert property (divider_reset
      |-> mini_holdover && feedback_phase_offset == 17'sh00000) else $error("early divider reset");
   a_offset_frozen: assert property ((!main_dpll_state[1] && !mini_holdover)[*3]
      |-> $stable(feedback_phase_offset)) else $error("offset moved outside locking");
   a_recalibrate_trigger_enter: assert property (wr && paddr == dpom_pkg::ADDR_FRAME_SYNC_CONFIG_THREE
      && pwdata[0] |-> ##[1:4] mini_holdover) else $error("recalibrate_trigger did not enter holdover");
endmodule : dpom_monitor
bind dpom_top dpom_monitor u_mon (.core_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
   .pwdata, .main_dpll_state, .aux_ref_mode, .feedback_phase_offset, .mini_holdover,
   .divider_reset, .aux_forced_input, .aux_lock_disable, .aux_pd_main_copy, .main_copy_mode);
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for dpom_top
// Assumes: 100 MHz core_clk, rst held 12 cycles, ce high but for one freeze check
// Notes:   readout bytes are compared in the low byte of prdata
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin err_total++; \
   $display("MISMATCH %0t %s", $time, m); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic               core_clk = '0, rst = '1, ce = '1, psel = '0, penable = '0, pwrite = '0;
   logic               buildout_event = '0, pd_sample = '0, main_divide_by_n_mode_is_8k = '0, seen;
   logic               aux_divide_by_n_mode_is_8k = '0, pready, pslverr, mini_holdover, divider_reset;
   logic               aux_lock_disable, aux_pd_main_copy;
   logic [7:0]         paddr = '0;
   logic [31:0]        pwdata = '0, prdata, rd;
   logic [1:0]         main_dpll_state = '0, main_ref_mode = '0, aux_ref_mode = '0;
   logic [1:0]         main_copy_mode, e;
   logic [3:0]         aux_forced_input;
   logic signed [17:0] buildout_phase = '0;
   logic signed [23:0] main_integral = '0, aux_integral = '0;
   logic signed [15:0] main_pd_diff = '0, aux_pd_diff = '0, reference_trim, ph;
   logic signed [16:0] feedback_phase_offset;
   int                 err_total = 0, checks = 0;
   dpom_top uut (.core_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .main_dpll_state, .buildout_event, .buildout_phase, .main_integral,
      .aux_integral, .pd_sample, .main_pd_diff, .aux_pd_diff, .main_ref_mode, .main_divide_by_n_mode_is_8k,
      .aux_ref_mode, .aux_divide_by_n_mode_is_8k, .feedback_phase_offset, .mini_holdover, .divider_reset,
      .aux_forced_input, .aux_lock_disable, .aux_pd_main_copy, .main_copy_mode, .reference_trim);
   // free-running core clock
   always #5 core_clk = ~core_clk;
   // one apb transfer; read data is taken at the edge that samples pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do @(posedge core_clk); while (pready !== 1'h1);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'h1, a, d); endtask : wr
   task automatic rdr(input logic [7:0] a); apb(1'h0, a, '0); endtask : rdr
   // wait, bounded, for the applied offset to settle
   task automatic wait_off(input logic signed [16:0] v);
      repeat (60) if (feedback_phase_offset !== v) @(posedge core_clk);
      `CHK(feedback_phase_offset, v, "applied offset")
   endtask : wait_off
   // offset register at reset and at both clamp limits, then an unmapped read
   task automatic t_regs;
      rdr(dpom_pkg::ADDR_PHASE_OFFSET);
      `CHK(rd, 32'h0, "offset reset")
      wr(dpom_pkg::ADDR_PHASE_OFFSET, 32'h00009C40);
      rdr(dpom_pkg::ADDR_PHASE_OFFSET);
      `CHK(rd, 32'(dpom_pkg::OFFSET_MAX), "high clamp")
      wr(dpom_pkg::ADDR_PHASE_OFFSET, 32'hFFFF63C0);
      rdr(dpom_pkg::ADDR_PHASE_OFFSET);
      `CHK(rd, -32'(dpom_pkg::OFFSET_MAX), "low clamp")
      rdr(8'h40);
      `CHK({pslverr, rd}, 33'h100000000, "unmapped read")
   endtask : t_regs
   // frequency: trim, snapshot on the first byte, range clamp, source select
   task automatic t_freq;
      main_integral <= 24'sh0003E8;
      aux_integral <= 24'sh000200;
      wr(dpom_pkg::ADDR_MASTER_CLOCK_TRIM, 32'h5);
      rdr(dpom_pkg::ADDR_FREQ1);
      `CHK(rd[7:0], 8'hE3, "trimmed freq")
      `CHK(reference_trim, 16'sh0005, "trim to core")
      main_integral <= 24'sh7FFFFF;
      rdr(dpom_pkg::ADDR_FREQ2);
      `CHK(rd[7:0], 8'h03, "snapshot")
      rdr(dpom_pkg::ADDR_FREQ1);
      rdr(dpom_pkg::ADDR_FREQ2);
      `CHK(rd[7:0], 8'hFA, "freq clamp")
      wr(dpom_pkg::ADDR_MASTER_CONFIG_ELEVEN, 32'h1);
      rdr(dpom_pkg::ADDR_FREQ1);
      `CHK(rd[7:0], 8'hFB, "aux freq")
   endtask : t_freq
   // phase: the average settles on each detector value; aux selected first
   task automatic t_phase;
      main_pd_diff <= 16'sh0064;
      aux_pd_diff <= 16'shFF9C;
      pd_sample <= 1'h1;
      repeat (200) @(posedge core_clk);
      pd_sample <= 1'h0;
      for (int s = 0; s < 2; s++) begin
         rdr(dpom_pkg::ADDR_PHASE1);
         ph[7:0] = rd[7:0];
         rdr(dpom_pkg::ADDR_PHASE2);
         ph[15:8] = rd[7:0];
         if (s == 0) `CHK(ph, 16'shFF9C, "aux phase")
         else `CHK(ph inside {16'sh0063, 16'sh0064}, 1'h1, "main phase")
         wr(dpom_pkg::ADDR_MASTER_CONFIG_ELEVEN, 32'h0);
      end
   endtask : t_phase
   // manual offset held in free-run, ramped in once locking
   task automatic t_offset;
      wr(dpom_pkg::ADDR_PHASE_OFFSET, 32'h000000A0);
      repeat (20) @(posedge core_clk);
      `CHK(feedback_phase_offset, 17'sh00000, "held in free-run")
      main_dpll_state <= dpom_pkg::ST_LOCKING;
      // clock enable low must hold the ramp even though the loop is locking
      ce <= 1'h0;
      repeat (5) @(posedge core_clk);
      `CHK(feedback_phase_offset, 17'sh00000, "ramp ran with ce low")
      ce <= 1'h1;
      wait_off(17'sh000A0);
   endtask : t_offset
   // build-out event adds a negative skew; disabling returns to the manual offset
   task automatic t_build;
      wr(dpom_pkg::ADDR_BUILDOUT_SKEW, 32'h000000FB);
      wr(dpom_pkg::ADDR_MASTER_CONFIG_TEN, 32'h1);
      buildout_phase <= 18'sh00064;
      buildout_event <= 1'h1;
      @(posedge core_clk);
      buildout_event <= 1'h0;
      wait_off(17'sh0005F);
      wr(dpom_pkg::ADDR_MASTER_CONFIG_TEN, 32'h0);
      wait_off(17'sh000A0);
   endtask : t_build
   // recalibration with an offset rewrite mid-run; final ramp must reach the new value
   task automatic t_recalibrate_trigger;
      seen = 1'h0;
      wr(dpom_pkg::ADDR_FRAME_SYNC_CONFIG_THREE, 32'h1);
      wr(dpom_pkg::ADDR_PHASE_OFFSET, 32'h00000140);
      repeat (200) begin
         @(posedge core_clk);
         if (divider_reset === 1'h1) seen = 1'h1;
         if (seen && mini_holdover === 1'h0) break;
      end
      `CHK(seen, 1'h1, "dividers reset")
      `CHK(feedback_phase_offset, 17'sh00140, "recalibrate_trigger target")
   endtask : t_recalibrate_trigger
   // cross measure: forced input, aux locking off, copy mode for every mode pairing
   task automatic t_cross;
      wr(dpom_pkg::ADDR_MASTER_CONFIG_FOUR, 32'h0000000B);
      wr(dpom_pkg::ADDR_MAIN_LOOP_CONFIG_ONE, 32'h1);
      // routing outputs lag the register by an edge, so look once they have settled
      @(negedge core_clk);
      `CHK({aux_forced_input, aux_lock_disable, aux_pd_main_copy}, 6'h2F, "cross")
      @(posedge core_clk);
      // bench drives every pairing of the three defined modes and both 8 kHz flags, matched rates or not
      for (int i = 0; i < 64; i++) begin
         if (i[1:0] == 2'h3 || i[4:3] == 2'h3) continue;
         aux_ref_mode <= i[1:0];
         aux_divide_by_n_mode_is_8k <= i[2];
         main_ref_mode <= i[4:3];
         main_divide_by_n_mode_is_8k <= i[5];
         repeat (2) @(posedge core_clk);
         e = dpom_pkg::MODE_DIRECT;
         if (i[1:0] == dpom_pkg::MODE_EIGHT_KHZ_LOCK_MODE || (i[1:0] == dpom_pkg::MODE_DIVIDE_BY_N_MODE && i[2]))
            e = (i[4:3] != dpom_pkg::MODE_DIVIDE_BY_N_MODE) ? dpom_pkg::MODE_EIGHT_KHZ_LOCK_MODE
                : (i[5] ? dpom_pkg::MODE_DIVIDE_BY_N_MODE : dpom_pkg::MODE_DIRECT);
         `CHK(main_copy_mode, e, "copy mode")
      end
      wr(dpom_pkg::ADDR_MAIN_LOOP_CONFIG_ONE, 32'h0);
      @(negedge core_clk);
      `CHK(aux_lock_disable, 1'h0, "cross off")
   endtask : t_cross
   // verdict and end of run
   task automatic wrap_up;
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // reset, then the scenarios in order
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'h0;
      @(posedge core_clk);
      t_regs();
      t_freq();
      t_phase();
      t_offset();
      t_build();
      t_recalibrate_trigger();
      t_cross();
      wrap_up();
   end
   // watchdog: the sequence needs a few thousand cycles at most
   initial begin
      #100us;
      err_total++;
      wrap_up();
   end
endmodule : tb
`default_nettype wire
